// file: rtl/als_wait_threshold_persist.v
// Purpose: wait timer, limit registers and persistence alert of a light sensor
// Assumes: register port driven by the serial target logic on this clock
// Notes:   measurement itself lives outside; vis_result carries its result, meas_done marks it
`default_nettype none
`include "als_wait_regs.vh"
module als_wait_threshold_persist #(
   parameter TICK_CYCLES = `WAIT_TICK_CYCLES
) (
   input  wire        clock,
   input  wire        srst,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata_r,
   input  wire        meas_done,
   input  wire [15:0] vis_result,
   output reg         meas_go_r,
   output reg         wait_active_r,
   output reg         int_out_r,
   output reg         int_oe_r
);
   // ==========================================
   // states
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_MEAS = 3'b010;
   localparam [2:0] ST_WAIT = 3'b100;

   reg  [7:0]  enable_r;
   reg  [7:0]  wait_period_count_r;
   reg  [7:0]  low_limit_lower_byte_r;
   reg  [7:0]  low_limit_upper_byte_r;
   reg  [7:0]  high_limit_lower_byte_r;
   reg  [7:0]  high_limit_upper_byte_r;
   reg  [15:0] low_limit_r;
   reg  [15:0] high_limit_r;
   reg  [7:0]  persist_config_r;
   reg  [7:0]  config_zero_r;
   reg  [7:0]  int_enable_r;
   reg         light_alert_flag_r;
   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [19:0] tick_cnt_r;
   reg  [11:0] ticks_left_r;
   wire        alert_pulse;
   wire        running;
   wire        tick;
   wire [11:0] wait_base;
   wire [11:0] wait_ticks;

   function wr_hit;
      input [7:0] ofs;
      begin
         wr_hit = reg_wr && (reg_addr == ofs);
      end
   endfunction

   // ==========================================
   // register writes
   always @(posedge clock) begin
      if (srst) begin
         enable_r                <= `RST_ENABLE;
         wait_period_count_r     <= `RST_WAIT_PERIOD;
         low_limit_lower_byte_r  <= `RST_LIMIT_BYTE;
         low_limit_upper_byte_r  <= `RST_LIMIT_BYTE;
         high_limit_lower_byte_r <= `RST_LIMIT_BYTE;
         high_limit_upper_byte_r <= `RST_LIMIT_BYTE;
         low_limit_r             <= {`RST_LIMIT_BYTE, `RST_LIMIT_BYTE};
         high_limit_r            <= {`RST_LIMIT_BYTE, `RST_LIMIT_BYTE};
         persist_config_r        <= `RST_PERSIST;
         config_zero_r           <= `RST_CONFIG_ZERO;
         int_enable_r            <= `RST_INT_ENABLE;
      end else begin
         if (wr_hit(`OFS_ENABLE)) begin
            enable_r <= reg_wdata;
         end
         if (wr_hit(`OFS_WAIT_PERIOD)) begin
            wait_period_count_r <= reg_wdata;
         end
         if (wr_hit(`OFS_LOW_LOWER)) begin
            low_limit_lower_byte_r <= reg_wdata;
         end
         if (wr_hit(`OFS_LOW_UPPER)) begin
            low_limit_upper_byte_r <= reg_wdata;
            low_limit_r            <= {reg_wdata, low_limit_lower_byte_r};
         end
         if (wr_hit(`OFS_HIGH_LOWER)) begin
            high_limit_lower_byte_r <= reg_wdata;
         end
         if (wr_hit(`OFS_HIGH_UPPER)) begin
            high_limit_upper_byte_r <= reg_wdata;
            high_limit_r            <= {reg_wdata, high_limit_lower_byte_r};
         end
         if (wr_hit(`OFS_PERSIST)) begin
            persist_config_r <= reg_wdata;
         end
         // reserved bits stored as written; host keeps them at default
         if (wr_hit(`OFS_CONFIG_ZERO)) begin
            config_zero_r <= reg_wdata;
         end
         if (wr_hit(`OFS_INT_ENABLE)) begin
            int_enable_r <= reg_wdata;
         end
      end
   end

   // ==========================================
   // status flag and interrupt pin
   always @(posedge clock) begin
      if (srst) begin
         light_alert_flag_r <= 1'b0;
         int_oe_r           <= 1'b0;
         int_out_r          <= 1'b0;
      end else begin
         if (wr_hit(`OFS_STATUS) && reg_wdata[`BIT_ALERT_FLAG]) begin
            light_alert_flag_r <= 1'b0;
         end
         // set beats a clear in the same cycle
         if (alert_pulse) begin
            light_alert_flag_r <= 1'b1;
         end
         int_oe_r  <= light_alert_flag_r & int_enable_r[`BIT_ALERT_IRQ_EN];
         int_out_r <= 1'b0;
      end
   end

   // ==========================================
   // register reads
   always @(posedge clock) begin
      if (srst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_ENABLE:      reg_rdata_r <= enable_r;
            `OFS_WAIT_PERIOD: reg_rdata_r <= wait_period_count_r;
            `OFS_LOW_LOWER:   reg_rdata_r <= low_limit_lower_byte_r;
            `OFS_LOW_UPPER:   reg_rdata_r <= low_limit_upper_byte_r;
            `OFS_HIGH_LOWER:  reg_rdata_r <= high_limit_lower_byte_r;
            `OFS_HIGH_UPPER:  reg_rdata_r <= high_limit_upper_byte_r;
            `OFS_PERSIST:     reg_rdata_r <= persist_config_r;
            `OFS_CONFIG_ZERO: reg_rdata_r <= config_zero_r;
            `OFS_STATUS:      reg_rdata_r <= {3'h0, light_alert_flag_r, 4'h0};
            `OFS_INT_ENABLE:  reg_rdata_r <= int_enable_r;
            default:          reg_rdata_r <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // measurement and wait sequencing
   assign running = enable_r[`BIT_POWER_ON] & enable_r[`BIT_MEASURE_EN];
   // widened to the parameter's 32 bits so the compare loses no bits
   assign tick    = ({12'h000, tick_cnt_r} == TICK_CYCLES - 1);
   assign wait_base  = {4'h0, wait_period_count_r} + 12'h001;
   assign wait_ticks = config_zero_r[`BIT_WAIT_X12] ? (wait_base * 12'h00c) : wait_base;

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (running) begin
               state_nxt = ST_MEAS;
            end
         end
         ST_MEAS: begin
            if (!running) begin
               state_nxt = ST_IDLE;
            end else if (meas_done && enable_r[`BIT_WAIT_EN]) begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!running) begin
               state_nxt = ST_IDLE;
            end else if (tick && (ticks_left_r == 12'h000)) begin
               state_nxt = ST_MEAS;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clock) begin
      if (srst) begin
         state_r       <= ST_IDLE;
         tick_cnt_r    <= 20'h00000;
         ticks_left_r  <= 12'h000;
         meas_go_r     <= 1'b0;
         wait_active_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         meas_go_r     <= (state_nxt == ST_MEAS);
         wait_active_r <= (state_nxt == ST_WAIT);
         if (state_r != ST_WAIT) begin
            tick_cnt_r   <= 20'h00000;
            ticks_left_r <= wait_ticks - 12'h001;
         end else if (tick) begin
            tick_cnt_r   <= 20'h00000;
            ticks_left_r <= ticks_left_r - 12'h001;
         end else begin
            tick_cnt_r <= tick_cnt_r + 20'h00001;
         end
      end
   end

   persist_filter u_persist (
      .clock                 (clock),
      .srst                  (srst),
      .result_valid          (meas_done && (state_r == ST_MEAS)),
      .vis_result            (vis_result),
      .low_limit             (low_limit_r),
      .high_limit            (high_limit_r),
      .persist_filter_select (persist_config_r[3:0]),
      .alert_pulse_r         (alert_pulse)
   );
endmodule // als_wait_threshold_persist
`default_nettype wire

// file: inc/als_wait_regs.vh
// Purpose: register offsets, fields, reset values and timing counts of the light alert block
// Assumes: byte-wide register port, 250 MHz clock
// Notes:   included by its bare name
`ifndef ALS_WAIT_REGS_VH
`define ALS_WAIT_REGS_VH
// ==========================================
// offsets
`define OFS_ENABLE       8'h80
`define OFS_WAIT_PERIOD  8'h83
`define OFS_LOW_LOWER    8'h84
`define OFS_LOW_UPPER    8'h85
`define OFS_HIGH_LOWER   8'h86
`define OFS_HIGH_UPPER   8'h87
`define OFS_PERSIST      8'h8c
`define OFS_CONFIG_ZERO  8'h8d
`define OFS_STATUS       8'h93
`define OFS_INT_ENABLE   8'hdd
// ==========================================
// field positions
`define BIT_POWER_ON     0
`define BIT_MEASURE_EN   1
`define BIT_WAIT_EN      3
`define BIT_WAIT_X12     2
`define BIT_ALERT_FLAG   4
`define BIT_ALERT_IRQ_EN 4
// ==========================================
// reset values
`define RST_ENABLE       8'h00
`define RST_WAIT_PERIOD  8'h00
`define RST_LIMIT_BYTE   8'h00
`define RST_PERSIST      8'h00
`define RST_CONFIG_ZERO  8'h80
`define RST_INT_ENABLE   8'h00
// ==========================================
// timing
`define CLK_PERIOD_NS    4
`define WAIT_TICK_NS     2800000
`define WAIT_TICK_CYCLES (`WAIT_TICK_NS / `CLK_PERIOD_NS)
`define WAIT_LONG_FACTOR 12
`endif

// file: rtl/persist_filter.v
// Purpose: consecutive out-of-range counter and alert decision per measurement
// Assumes: one result_valid pulse per completed visible measurement
// Notes:   counter saturates at a nonzero requirement (at 63 when it is zero) so long runs keep alerting
`default_nettype none
module persist_filter (
   input  wire        clock,
   input  wire        srst,
   input  wire        result_valid,
   input  wire [15:0] vis_result,
   input  wire [15:0] low_limit,
   input  wire [15:0] high_limit,
   input  wire [3:0]  persist_filter_select,
   output reg         alert_pulse_r
);
   // ==========================================
   // decode
   reg  [5:0] run_r;
   reg  [5:0] run_nxt;
   reg  [5:0] need;
   wire       below;
   wire       above;
   wire       outside;

   assign below   = vis_result < low_limit;
   assign above   = vis_result > high_limit;
   assign outside = below | above;

   always @* begin
      need = 6'h00;
      if (persist_filter_select < 4'h4) begin
         need = {2'h0, persist_filter_select};
      end else begin
         need = 6'h05 * {2'h0, persist_filter_select - 4'h3};
      end
   end

   // ==========================================
   // counter and decision
   always @* begin
      run_nxt = run_r;
      if (!outside) begin
         run_nxt = 6'h00;
      end else if (run_r < 6'h3f) begin
         run_nxt = run_r + 6'h01;
      end
      if ((need != 6'h00) && (run_nxt > need)) begin
         run_nxt = need;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         run_r         <= 6'h00;
         alert_pulse_r <= 1'b0;
      end else begin
         alert_pulse_r <= 1'b0;
         if (result_valid) begin
            run_r <= run_nxt;
            if (need == 6'h00) begin
               alert_pulse_r <= 1'b1;
            end else if (outside && (run_nxt == need)) begin
               alert_pulse_r <= 1'b1;
            end
         end
      end
   end
endmodule // persist_filter
`default_nettype wire

// file: bench/host_model.sv
// Purpose: host side of the register port
// Assumes: calls start 1 ns after a rising edge
// Notes:   released lines show the inverse of the last value
`default_nettype none
// ==========
// host
module host_model (
   input wire logic       clock,
   output logic     [7:0] reg_addr,
   output logic     [7:0] reg_wdata,
   output logic           reg_wr,
   output logic           reg_rd,
   input wire logic [7:0] reg_rdata_r
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
   // idle cycle after each write so the strobe never toggles twice at once
   task wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clock) #1;
      reg_wr = 1'b0;
      reg_wdata = ~v;
      @(posedge clock) #1;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock) #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge clock) #1;
      v = reg_rdata_r;
   endtask
   task set_lim(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, v[15:8]);
   endtask
   task set_cfg(input logic x12);
      wr(8'h8d, {5'b10000, x12, 2'b00});
   endtask
endmodule // host_model
`default_nettype wire

// file: bench/als_wait_chk.sv
// Purpose: port checks of the light alert block
// Assumes: TICK_CYCLES shortened as in the bench
// Notes:   bound to the design top
`default_nettype none
// ==========
// checker
module als_wait_chk #(
   parameter TICK_CYCLES = 4
) (
   input wire logic       clock,
   input wire logic       srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic       meas_done,
   input wire logic       meas_go_r,
   input wire logic       wait_active_r,
   input wire logic       int_out_r,
   input wire logic       int_oe_r
);
   timeunit 1ns;
   timeprecision 1ps;
   int wcnt;
   // length of the running wait phase
   always @(posedge clock) wcnt <= (srst || !wait_active_r) ? 0 : wcnt + 1;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   property p_pin; int_out_r == 1'b0; endproperty
   a_pin: assert property (p_pin) else $error("pin level not low");
   property p_excl; !(meas_go_r && wait_active_r); endproperty
   a_excl: assert property (p_excl) else $error("wait during measure");
   property p_wgo; $rose(wait_active_r) |-> $past(meas_done) || $past(meas_done, 2); endproperty
   a_wgo: assert property (p_wgo) else $error("wait without result");
   property p_wlen; $fell(wait_active_r) |-> wcnt >= TICK_CYCLES; endproperty
   a_wlen: assert property (p_wlen) else $error("wait too short");
   property p_irq; $rose(int_oe_r) |-> $past(meas_done, 3) || $past(reg_wr, 2); endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");
   property p_rel; $fell(int_oe_r) |-> $past(reg_wr && reg_addr == 8'h93 && reg_wdata[4], 2); endproperty
   a_rel: assert property (p_rel) else $error("irq dropped without clear");
   property p_wrb;
      reg_wr && reg_addr == 8'h83 ##2 reg_rd && reg_addr == 8'h83 |=> reg_rdata_r == $past(reg_wdata, 3);
   endproperty
   a_wrb: assert property (p_wrb) else $error("wait period readback");
   property p_flag; reg_rd && reg_addr == 8'h93 && int_oe_r && !$past(reg_wr) |=> reg_rdata_r[4]; endproperty
   a_flag: assert property (p_flag) else $error("flag not in status");
   c_wait: cover property ($rose(wait_active_r));
   c_irq: cover property ($rose(int_oe_r));
   c_rel: cover property ($fell(int_oe_r));
endmodule // als_wait_chk
bind als_wait_threshold_persist als_wait_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.clock(clock), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
   .meas_done(meas_done), .meas_go_r(meas_go_r), .wait_active_r(wait_active_r), .int_out_r(int_out_r),
   .int_oe_r(int_oe_r));
`default_nettype wire

// file: bench/als_wait_threshold_persist_tb.sv
// Purpose: self-checking bench of the light alert block
// Assumes: wait tick shortened to T cycles
// Notes:   model keeps limits and counter as integers, flag as one logic bit
`default_nettype none
// ==========
// bench
module als_wait_threshold_persist_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T = 4;
   logic        clock, srst, reg_wr, reg_rd, meas_done, meas_go_r, wait_active_r, int_out_r, int_oe_r;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, d;
   logic [15:0] vis_result;
   logic        flag_m;
   int          failures, comparisons, lo, hi, cnt, need, n, w, nw, r;
   logic [7:0]  ra [4] = '{8'h80, 8'h83, 8'h8d, 8'h40};
   logic [7:0]  rv [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
   host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));
   als_wait_threshold_persist #(.TICK_CYCLES(T)) uut (.clock(clock), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .meas_done(meas_done), .vis_result(vis_result), .meas_go_r(meas_go_r),
      .wait_active_r(wait_active_r), .int_out_r(int_out_r), .int_oe_r(int_oe_r));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task check(input string nm, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task print_verdict;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // a hang counts as a mismatch
   task step;
      @(posedge clock) #1;
      n++;
      if (n > 3000) begin
         failures++;
         print_verdict;
      end
   endtask
   task pulse(input logic [15:0] v);
      n = 0;
      while (meas_go_r !== 1'b1)
         step;
      meas_done = 1'b1;
      vis_result = v;
      @(posedge clock) #1;
      meas_done = 1'b0;
      vis_result = ~v;
   endtask
   task sample(input logic [15:0] v);
      pulse(v);
      cnt = (v < lo || v > hi) ? cnt + 1 : 0;
      if (cnt >= need)
         flag_m = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      host.rd(8'h93, d);
      check("alert flag", d[4], flag_m);
      check("irq pin", int_oe_r, flag_m);
      check("no wait", wait_active_r, 1'b0);
   endtask
   function logic [15:0] outside;
      outside = 16'($urandom % 2 ? lo - 1 - $urandom % 16 : hi + 1 + $urandom % 16);
   endfunction
   initial begin
      {srst, meas_done, vis_result, flag_m} = 19'h40000;
      r = $urandom(77);
      repeat (3) @(posedge clock);
      #1;
      srst = 1'b0;
      foreach (ra[i]) begin
         host.rd(ra[i], d);
         check("reset value", d, rv[i]);
      end
      check("int level", int_out_r, 1'b0);
      host.wr(8'hdd, 8'h10);
      host.wr(8'h80, 8'h03);
      lo = 'h1000 + $urandom % 256;
      hi = lo + 'h1000 + $urandom % 256 | 1;
      host.set_lim(8'h84, lo[15:0]);
      host.set_lim(8'h86, hi[15:0]);
      // a lone lower byte must stay in the shadow
      host.wr(8'h86, 8'h00);
      host.rd(8'h86, d);
      check("shadow byte", d, 8'h00);
      host.rd(8'h87, d);
      check("high upper byte", d, hi[15:8]);
      for (int p = 0; p < 16; p++) begin
         host.wr(8'h8c, 8'(p));
         host.rd(8'h8c, d);
         check("persist select", d, 8'(p));
         need = p < 4 ? p : 5 * (p - 3);
         sample(lo[15:0]);
         host.wr(8'h93, 8'h10);
         flag_m = 1'b0;
         host.rd(8'h93, d);
         check("flag clear", d[4], 1'b0);
         for (int i = 0; i < 2 * need + 1; i++)
            sample(i == need - 1 && need > 1 ? hi[15:0] : outside());
      end
      host.wr(8'h80, 8'h0b);
      for (int i = 0; i < 4; i++) begin
         w = $urandom % 4;
         host.wr(8'h83, 8'(w));
         host.rd(8'h83, d);
         check("wait period", d, 8'(w));
         host.set_cfg(i[0]);
         nw = (w + 1) * (i[0] ? 12 : 1) * T;
         pulse(hi[15:0]);
         check("wait active", wait_active_r, 1'b1);
         n = 0;
         while (meas_go_r === 1'b1)
            step;
         while (meas_go_r !== 1'b1)
            step;
         check("wait length", n >= nw && n <= nw + 4, 1'b1);
      end
      host.wr(8'h80, 8'h00);
      check("idle", meas_go_r, 1'b0);
      print_verdict;
   end
endmodule // als_wait_threshold_persist_tb
`default_nettype wire
